// file: rtl/addr_scalar_exec.sv
/*
 Address-side execution unit: branches on A0/S0, immediate loads, A/S/B
 transfers, bit counts, address arithmetic and channel status reads.
 Assumes the issue logic supplies Sj and S0 alongside the parcel and that
 channel logic answers the selected channel's address combinationally.
*/
`timescale 1ns/1ns
`default_nettype none
module addr_scalar_exec (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    // Issue
    input  wire logic        ISSUE_VALID,
    input  wire logic [15:0] ISSUE_PARCEL,
    input  wire logic [15:0] ISSUE_PARCEL2,
    input  wire logic [63:0] SCALAR_J_VALUE,
    input  wire logic [63:0] SCALAR_ZERO_VALUE,
    input  wire logic        MONITOR_MODE,
    output logic             ISSUE_READY,
    // Results
    output logic             DONE,
    output logic             BRANCH_TAKEN,
    output logic [23:0]      BRANCH_TARGET,
    output logic             A_WRITE,
    output logic [2:0]       A_WRITE_INDEX,
    output logic [23:0]      A_WRITE_DATA,
    // Channels
    input  wire logic [4:0]  CHAN_TOP_INTERRUPT,
    input  wire logic [23:0] CHAN_CA_VALUE,
    input  wire logic [25:0] CHAN_ERR_SET,
    output logic [4:0]       CHAN_SEL,
    output logic [25:0]      CHAN_ERR_FLAGS
);
    unit_if u_bus ();

    addr_exec_pkg::state_t state_reg, state_next;
    logic [15:0] p0_reg, p0_next, p1_reg, p1_next;
    logic [63:0] sj_reg, sj_next, s0_reg, s0_next;
    logic        mon_reg, mon_next, chan_ok_reg, chan_ok_next;
    logic        ready_next, done_next, taken_next, awr_next;
    logic [23:0] target_next, adata_next;
    logic [2:0]  aidx_next;
    logic [4:0]  sel_next;
    logic [25:0] err_next;
    logic [23:0] a_reg [addr_exec_pkg::AREGS];
    logic [23:0] a_next [addr_exec_pkg::AREGS];

    logic        accept;
    logic [6:0]  op, in_op;
    logic [2:0]  fi, fj, fk, in_j;
    logic [23:0] aj_op, ak_op, ajv_in, prod;
    logic        cond;
    logic        err_clr;
    logic        a0_zero_w, s0_neg_w;
    logic [5:0]  issue_jk_w;
    logic [21:0] issue_jkm_w;

    assign accept = ISSUE_VALID && ISSUE_READY;
    // Parcel decode
    assign in_op  = ISSUE_PARCEL[addr_exec_pkg::OP_MSB:addr_exec_pkg::OP_LSB]; // RULE18
    assign in_j   = ISSUE_PARCEL[addr_exec_pkg::J_LSB +: 3];
    assign ajv_in = a_reg[in_j];
    assign op     = p0_reg[addr_exec_pkg::OP_MSB:addr_exec_pkg::OP_LSB]; // RULE18
    assign fi     = p0_reg[addr_exec_pkg::I_LSB +: 3];
    assign fj     = p0_reg[addr_exec_pkg::J_LSB +: 3];
    assign fk     = p0_reg[addr_exec_pkg::K_LSB +: 3];
    // Zero designators read as 0 (j) and 1 (k): covers every special case
    assign aj_op  = (fj == 3'h0) ? 24'h000000 : a_reg[fj]; // RULE12 RULE13 RULE14
    assign ak_op  = (fk == 3'h0) ? 24'h000001 : a_reg[fk]; // RULE12 RULE13 RULE14
    assign prod   = 24'(aj_op * ak_op); // RULE14

    // Helpers for checks
    assign a0_zero_w   = (a_reg[0] == 24'h000000);
    assign s0_neg_w    = SCALAR_ZERO_VALUE[63];
    assign issue_jk_w  = ISSUE_PARCEL[5:0];
    assign issue_jkm_w = {ISSUE_PARCEL[5:0], ISSUE_PARCEL2};

    // Backup read index is taken straight from the parcel so data is ready in EXEC
    assign u_bus.mem_raddr   = ISSUE_PARCEL[5:0]; // RULE9
    assign u_bus.mem_we      = (state_reg == addr_exec_pkg::ST_EXEC) && (op == addr_exec_pkg::OP_TO_B);
    assign u_bus.mem_waddr   = p0_reg[5:0];
    assign u_bus.mem_wdata   = a_reg[fi]; // RULE9
    assign u_bus.cnt_operand = sj_reg;

    backup_regfile u_breg (
        .SYS_CLK (SYS_CLK),
        .bus     (u_bus)
    );

    bit_counter u_cnt (
        .bus (u_bus)
    );

    // Branch condition: zero counts as positive
    always_comb begin
        logic zero;
        logic neg;
        zero = op[2] ? (s0_reg == 64'h0) : (a_reg[0] == 24'h000000); // RULE4
        neg  = op[2] ? s0_reg[63] : a_reg[0][23]; // RULE2 RULE4
        case (op[1:0])
            2'h0:    cond = zero; // RULE1
            2'h1:    cond = !zero; // RULE1
            2'h2:    cond = !neg; // RULE2
            default: cond = neg; // RULE1
        endcase
    end

    assign err_clr = (state_reg == addr_exec_pkg::ST_EXEC) && (op == addr_exec_pkg::OP_CHAN_CTL)
                     && (fi == addr_exec_pkg::I_ERR_CLEAR) && mon_reg && chan_ok_reg;

    // Issue capture and sequencing
    always_comb begin
        state_next   = state_reg;
        p0_next      = p0_reg;
        p1_next      = p1_reg;
        sj_next      = sj_reg;
        s0_next      = s0_reg;
        mon_next     = mon_reg;
        chan_ok_next = chan_ok_reg;
        sel_next     = CHAN_SEL;
        case (state_reg)
            addr_exec_pkg::ST_IDLE: begin
                if (accept) begin
                    p0_next      = ISSUE_PARCEL;
                    p1_next      = ISSUE_PARCEL2;
                    sj_next      = (in_j == 3'h0) ? 64'h0 : SCALAR_J_VALUE;
                    s0_next      = SCALAR_ZERO_VALUE;
                    mon_next     = MONITOR_MODE;
                    sel_next     = ajv_in[4:0];
                    chan_ok_next = (in_j != 3'h0) && (ajv_in >= addr_exec_pkg::CHAN_FIRST)
                                   && (ajv_in <= addr_exec_pkg::CHAN_LAST);
                    state_next   = addr_exec_pkg::ST_EXEC;
                end
            end
            addr_exec_pkg::ST_EXEC: state_next = addr_exec_pkg::ST_IDLE;
            default:                state_next = addr_exec_pkg::ST_IDLE;
        endcase
        ready_next = (state_next == addr_exec_pkg::ST_IDLE);
    end

    // Execution of the latched parcel
    always_comb begin
        done_next   = 1'b0;
        taken_next  = 1'b0;
        target_next = BRANCH_TARGET;
        awr_next    = 1'b0;
        aidx_next   = A_WRITE_INDEX;
        adata_next  = A_WRITE_DATA;
        a_next      = a_reg;
        // Set wins over a clear in the same cycle
        err_next    = (CHAN_ERR_FLAGS & ~(err_clr ? (26'h1 << CHAN_SEL) : 26'h0))
                      | CHAN_ERR_SET; // RULE17
        if (state_reg == addr_exec_pkg::ST_EXEC) begin
            done_next = 1'b1;
            aidx_next = fi;
            awr_next  = 1'b1;
            case (op)
                addr_exec_pkg::OP_IMM_LONG:  adata_next = {2'h0, p0_reg[5:0], p1_reg}; // RULE5
                addr_exec_pkg::OP_IMM_COMPL: adata_next = ~{2'h0, p0_reg[5:0], p1_reg}; // RULE6
                addr_exec_pkg::OP_IMM_SHORT: adata_next = {18'h0, p0_reg[5:0]}; // RULE7
                addr_exec_pkg::OP_FROM_S:    adata_next = sj_reg[23:0]; // RULE8
                addr_exec_pkg::OP_FROM_B:    adata_next = u_bus.mem_rdata; // RULE9
                addr_exec_pkg::OP_POP:       adata_next = {17'h0, u_bus.cnt_ones}; // RULE10
                addr_exec_pkg::OP_LEAD: begin
                    adata_next = (fj == 3'h0) ? {17'h0, addr_exec_pkg::LZ_ALL_ZERO}
                                              : {17'h0, u_bus.cnt_lead}; // RULE11
                end
                addr_exec_pkg::OP_ADD:       adata_next = aj_op + ak_op; // RULE12
                addr_exec_pkg::OP_SUB:       adata_next = aj_op - ak_op; // RULE13
                addr_exec_pkg::OP_MUL:       adata_next = prod; // RULE14
                addr_exec_pkg::OP_CHAN: begin
                    if (fj == 3'h0) begin
                        adata_next = {19'h0, CHAN_TOP_INTERRUPT}; // RULE15
                    end else if (!chan_ok_reg) begin
                        adata_next = 24'h000000;
                    end else if (fk == 3'h0) begin
                        adata_next = CHAN_CA_VALUE; // RULE16
                    end else if (fk == 3'h1) begin
                        adata_next = {23'h0, CHAN_ERR_FLAGS[CHAN_SEL]}; // RULE16 RULE17
                    end else begin
                        adata_next = 24'h000000;
                    end
                end
                default: begin
                    awr_next = 1'b0;
                    if (op >= addr_exec_pkg::OP_BR_AZ && op <= addr_exec_pkg::OP_BR_SM) begin
                        taken_next  = cond; // RULE1 RULE4
                        target_next = {p0_reg[7:0], p1_reg}; // RULE3
                    end
                end
            endcase
            if (awr_next) begin
                a_next[fi] = adata_next;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg      <= addr_exec_pkg::ST_IDLE;
            p0_reg         <= 16'h0000;
            p1_reg         <= 16'h0000;
            sj_reg         <= 64'h0;
            s0_reg         <= 64'h0;
            mon_reg        <= 1'b0;
            chan_ok_reg    <= 1'b0;
            ISSUE_READY    <= 1'b1;
            DONE           <= 1'b0;
            BRANCH_TAKEN   <= 1'b0;
            BRANCH_TARGET  <= 24'h000000;
            A_WRITE        <= 1'b0;
            A_WRITE_INDEX  <= 3'h0;
            A_WRITE_DATA   <= 24'h000000;
            CHAN_SEL       <= 5'h00;
            CHAN_ERR_FLAGS <= 26'h0;
            for (int n = 0; n < addr_exec_pkg::AREGS; n++) begin
                a_reg[n] <= addr_exec_pkg::A_RESET;
            end
        end else begin
            state_reg      <= state_next;
            p0_reg         <= p0_next;
            p1_reg         <= p1_next;
            sj_reg         <= sj_next;
            s0_reg         <= s0_next;
            mon_reg        <= mon_next;
            chan_ok_reg    <= chan_ok_next;
            ISSUE_READY    <= ready_next;
            DONE           <= done_next;
            BRANCH_TAKEN   <= taken_next;
            BRANCH_TARGET  <= target_next;
            A_WRITE        <= awr_next;
            A_WRITE_INDEX  <= aidx_next;
            A_WRITE_DATA   <= adata_next;
            CHAN_SEL       <= sel_next;
            CHAN_ERR_FLAGS <= err_next;
            a_reg          <= a_next;
        end
    end

    // Checks
    a_issue_latency: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE18
        accept |-> ##2 DONE)
        else $error("done not two cycles after issue");
    a_addr_zero_branch: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE1
        accept && in_op == addr_exec_pkg::OP_BR_AZ |-> ##2 BRANCH_TAKEN == $past(a0_zero_w, 2))
        else $error("A0 zero branch wrong");
    a_zero_positive: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE2
        accept && in_op == addr_exec_pkg::OP_BR_AP && a0_zero_w |-> ##2 BRANCH_TAKEN)
        else $error("zero A0 not positive");
    a_branch_target: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE3
        DONE && BRANCH_TAKEN |-> BRANCH_TARGET == $past({ISSUE_PARCEL[7:0], ISSUE_PARCEL2}, 2)
        && !A_WRITE)
        else $error("branch target wrong");
    a_scalar_minus: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE4
        accept && in_op == addr_exec_pkg::OP_BR_SM |-> ##2 BRANCH_TAKEN == $past(s0_neg_w, 2))
        else $error("S0 minus branch wrong");
    a_imm_compl: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE6
        accept && in_op == addr_exec_pkg::OP_IMM_COMPL
        |-> ##2 A_WRITE && A_WRITE_DATA == ~{2'h0, $past(issue_jkm_w, 2)})
        else $error("complemented load wrong");
    a_imm_short: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE7
        accept && in_op == addr_exec_pkg::OP_IMM_SHORT
        |-> ##2 A_WRITE && A_WRITE_DATA == {18'h0, $past(issue_jk_w, 2)})
        else $error("short load wrong");
    a_lead_empty: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE11
        accept && in_op == addr_exec_pkg::OP_LEAD && in_j == 3'h0 |-> ##2 A_WRITE_DATA == 24'h000040)
        else $error("leading zero of j zero not 64");
    a_add_both_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE12
        accept && in_op == addr_exec_pkg::OP_ADD && ISSUE_PARCEL[5:0] == 6'h00
        |-> ##2 A_WRITE_DATA == 24'h000001)
        else $error("add of zero designators not one");
    a_err_sticky: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // RULE17
        !err_clr |=> (CHAN_ERR_FLAGS & $past(CHAN_ERR_FLAGS)) == $past(CHAN_ERR_FLAGS))
        else $error("error flag dropped without clear");
    c_taken_branch: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) DONE && BRANCH_TAKEN);
    c_backup_write: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) u_bus.mem_we);
    c_chan_error:   cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
        DONE && A_WRITE && op == addr_exec_pkg::OP_CHAN && fk == 3'h1 && A_WRITE_DATA[0]);
    c_err_clear:    cover property (@(posedge SYS_CLK) disable iff (!ARST_N) err_clr);
endmodule // addr_scalar_exec
`default_nettype wire

// file: rtl/addr_exec_pkg.sv
/*
 Constants, opcodes, field positions and state codes for the address and scalar
 execution unit. Assumes a single clock domain and a 16-bit parcel layout.
*/
// Overview of operation
// RULE1: Opcodes 010-013 branch on A0 condition
// RULE2: Zero in A0 counts as positive
// RULE3: Taken branch target is low 24 bits
// RULE4: Opcodes 014-017 same tests on S0
// RULE5: 020 loads jkm unsigned, upper bits cleared
// RULE6: 021 loads complemented zero-extended jkm
// RULE7: 022 loads six-bit jk zero-extended
// RULE8: 023 copies low Sj bits, j zero clears
// RULE9: 024/025 move between A and backup
// RULE10: 026 population count, j zero clears
// RULE11: 027 leading zeros, j zero gives 64
// RULE12: 030 add, zero designators give special values
// RULE13: 031 subtract, zero designators give specials
// RULE14: 032 multiply low 24, zero designator cases
// RULE15: 033 j zero returns top interrupt channel
// RULE16: 033 nonzero j reads address or error
// RULE17: Error flag sticky until monitor clear
// RULE18: Parcel is opcode, i, j, k fields
`default_nettype none
package addr_exec_pkg;
    localparam int unsigned AW        = 24;
    localparam int unsigned SW        = 64;
    localparam int unsigned PW        = 16;
    localparam int unsigned CNTW      = 7;
    localparam int unsigned BIDXW     = 6;
    localparam int unsigned BDEPTH    = 64;
    localparam int unsigned CHW       = 5;
    localparam int unsigned CHAN_NUM  = 26;
    localparam int unsigned AREGS     = 8;

    // Parcel field positions
    localparam int unsigned OP_MSB    = 15;
    localparam int unsigned OP_LSB    = 9;
    localparam int unsigned I_LSB     = 6;
    localparam int unsigned J_LSB     = 3;
    localparam int unsigned K_LSB     = 0;

    localparam logic [6:0] OP_CHAN_CTL  = 7'h01;
    localparam logic [6:0] OP_BR_AZ     = 7'h08;
    localparam logic [6:0] OP_BR_AN     = 7'h09;
    localparam logic [6:0] OP_BR_AP     = 7'h0a;
    localparam logic [6:0] OP_BR_AM     = 7'h0b;
    localparam logic [6:0] OP_BR_SZ     = 7'h0c;
    localparam logic [6:0] OP_BR_SM     = 7'h0f;
    localparam logic [6:0] OP_IMM_LONG  = 7'h10;
    localparam logic [6:0] OP_IMM_COMPL = 7'h11;
    localparam logic [6:0] OP_IMM_SHORT = 7'h12;
    localparam logic [6:0] OP_FROM_S    = 7'h13;
    localparam logic [6:0] OP_FROM_B    = 7'h14;
    localparam logic [6:0] OP_TO_B      = 7'h15;
    localparam logic [6:0] OP_POP       = 7'h16;
    localparam logic [6:0] OP_LEAD      = 7'h17;
    localparam logic [6:0] OP_ADD       = 7'h18;
    localparam logic [6:0] OP_SUB       = 7'h19;
    localparam logic [6:0] OP_MUL       = 7'h1a;
    localparam logic [6:0] OP_CHAN      = 7'h1b;

    localparam logic [2:0] I_ERR_CLEAR  = 3'h2;
    localparam logic [6:0] LZ_ALL_ZERO  = 7'h40;
    localparam logic [23:0] CHAN_FIRST  = 24'h000002;
    localparam logic [23:0] CHAN_LAST   = 24'h000019;
    localparam logic [23:0] A_RESET     = 24'h000000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_t;
endpackage
`default_nettype wire

// file: rtl/unit_if.sv
/*
 Carrier between the execution core, its backup register store and its bit
 counter. Assumes all three run on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface unit_if;
    logic        mem_we;
    logic [5:0]  mem_waddr;
    logic [5:0]  mem_raddr;
    logic [23:0] mem_wdata;
    logic [23:0] mem_rdata;
    logic [63:0] cnt_operand;
    logic [6:0]  cnt_ones;
    logic [6:0]  cnt_lead;

    modport core (output mem_we, mem_waddr, mem_raddr, mem_wdata, cnt_operand,
                  input mem_rdata, cnt_ones, cnt_lead);
    modport mem  (input mem_we, mem_waddr, mem_raddr, mem_wdata, output mem_rdata);
    modport cnt  (input cnt_operand, output cnt_ones, cnt_lead);
endinterface
`default_nettype wire

// file: rtl/backup_regfile.sv
/*
 Sixty-four 24-bit backup registers with a registered read port.
 Assumes the core presents the read index one cycle before it needs the data.
*/
`timescale 1ns/1ns
`default_nettype none
module backup_regfile (
    // Clock
    input wire logic SYS_CLK,
    // Store port
    unit_if.mem      bus
);
    logic [23:0] store [addr_exec_pkg::BDEPTH];
    logic [23:0] rdata_reg;

    // Contents are undefined after reset, as in the register file it models
    always_ff @(posedge SYS_CLK) begin
        if (bus.mem_we) begin
            store[bus.mem_waddr] <= bus.mem_wdata; // RULE9
        end
        rdata_reg <= store[bus.mem_raddr];
    end

    assign bus.mem_rdata = rdata_reg;
endmodule // backup_regfile
`default_nettype wire

// file: rtl/bit_counter.sv
/*
 Population count and leading-zero count of one 64-bit scalar operand.
 Purely combinational; the core registers the results.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_counter (
    // Operand and counts
    unit_if.cnt bus
);
    logic [6:0] ones;
    logic [6:0] lead;
    logic       found;

    always_comb begin
        ones  = 7'h00;
        lead  = addr_exec_pkg::LZ_ALL_ZERO;
        found = 1'b0;
        for (int n = 63; n >= 0; n--) begin
            ones = ones + {6'h00, bus.cnt_operand[n]}; // RULE10
            if (!found && bus.cnt_operand[n]) begin
                lead  = 7'(63 - n); // RULE11
                found = 1'b1;
            end
        end
    end

    assign bus.cnt_ones = ones;
    assign bus.cnt_lead = lead;
endmodule // bit_counter
`default_nettype wire

// file: tb/addr_scalar_exec_tb_top.sv
/*
 Self-checking bench for the address-side execution unit: a bench model of
 A, B and channel flags is compared with every result.
 Assumes the unit answers two cycles after a taken parcel.
*/
`timescale 1ns/1ns
`default_nettype none
module addr_scalar_exec_tb_top;
    logic        sys_clk;
    logic        arst_n;
    logic        issue_valid;
    logic [15:0] parcel;
    logic [15:0] parcel2;
    logic [63:0] sj_val;
    logic [63:0] s0_val;
    logic        mon;
    logic [4:0]  top_int;
    logic [25:0] err_set;
    logic [23:0] ca_val;
    logic        ready;
    logic        done;
    logic        br_taken;
    logic        a_wr;
    logic [23:0] br_tgt;
    logic [23:0] a_data;
    logic [2:0]  a_idx;
    logic [4:0]  chan_sel;
    logic [25:0] err_flags;
    integer      seed;
    int          num_errors;
    int          checks_done;
    logic [23:0] a_m [8];
    logic [23:0] b_m [64];
    logic [25:0] flags_m;

    // Distinct current address per channel, so a wrong select shows
    assign ca_val = {3'h5, chan_sel, 11'h2a1, chan_sel};

    addr_scalar_exec dut_u (
        .SYS_CLK            (sys_clk),
        .ARST_N             (arst_n),
        .ISSUE_VALID        (issue_valid),
        .ISSUE_PARCEL       (parcel),
        .ISSUE_PARCEL2      (parcel2),
        .SCALAR_J_VALUE     (sj_val),
        .SCALAR_ZERO_VALUE  (s0_val),
        .MONITOR_MODE       (mon),
        .ISSUE_READY        (ready),
        .DONE               (done),
        .BRANCH_TAKEN       (br_taken),
        .BRANCH_TARGET      (br_tgt),
        .A_WRITE            (a_wr),
        .A_WRITE_INDEX      (a_idx),
        .A_WRITE_DATA       (a_data),
        .CHAN_TOP_INTERRUPT (top_int),
        .CHAN_CA_VALUE      (ca_val),
        .CHAN_ERR_SET       (err_set),
        .CHAN_SEL           (chan_sel),
        .CHAN_ERR_FLAGS     (err_flags)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic [23:0] popcnt(input logic [63:0] v);
        popcnt = 24'h0;
        for (int n = 0; n < 64; n++) popcnt = popcnt + v[n];
    endfunction

    // Counts from the top; an all-zero operand gives 64
    function automatic logic [23:0] lzc(input logic [63:0] v);
        lzc = 24'h40;
        for (int n = 0; n < 64; n++) if (v[n]) lzc = 24'd63 - n;
    endfunction

    task automatic exec(input logic [6:0] op, input logic [2:0] i, j, k, input logic [15:0] m);
        logic [63:0] sj;
        logic [63:0] s0;
        logic [63:0] sje;
        logic        md;
        logic [4:0]  ti;
        logic [25:0] set;
        logic [23:0] aj;
        logic [23:0] ak;
        logic [23:0] res;
        logic [23:0] tgt;
        logic [4:0]  ch;
        logic        ok;
        logic        wr;
        logic        br;
        logic        zero;
        logic        neg;
        sj = {$random(seed), $random(seed)};
        s0 = {$random(seed), $random(seed)};
        if (s0[1:0] == 2'h0) s0 = 64'h0;
        md = $random(seed);
        ti = $random(seed);
        set = (sj[7:5] == 3'h0) ? (26'h1 << (sj[15:8] % 26)) : 26'h0;
        @(posedge sys_clk);
        issue_valid <= 1'b1;
        parcel      <= {op, i, j, k};
        parcel2     <= m;
        sj_val      <= sj;
        s0_val      <= s0;
        mon         <= md;
        top_int     <= ti;
        err_set     <= set;
        #1 chk("done_low", done, 1'b0);
        @(posedge sys_clk);
        issue_valid <= 1'b0;
        err_set     <= 26'h0;
        // Busy only in the execute cycle right after acceptance
        #1 chk("ready_busy", ready, 1'b0);
        if (j != 3'h0) chk("chan_sel", chan_sel, a_m[j][4:0]);
        flags_m = flags_m | set;
        sje = (j == 3'h0) ? 64'h0 : sj;
        aj = (j == 3'h0) ? 24'h0 : a_m[j];
        ak = (k == 3'h0) ? 24'h1 : a_m[k];
        ch = a_m[j][4:0];
        ok = (j != 3'h0) && (a_m[j] >= 24'd2) && (a_m[j] <= 24'd25);
        tgt = {i[1:0], j, k, m};
        zero = (op[2] == 1'b0) ? (a_m[0] == 24'h0) : (s0 == 64'h0);
        neg = (op[2] == 1'b0) ? a_m[0][23] : s0[63];
        wr = 1'b1;
        br = 1'b0;
        res = 24'h0;
        case (op)
            7'h01: begin
                wr = 1'b0;
                if (md && i == 3'h2 && ok) flags_m[ch] = 1'b0;
            end
            7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f: begin
                wr = 1'b0;
                br = op[1] ? (op[0] ? neg : !neg) : (op[0] ? !zero : zero);
            end
            7'h10: res = {2'h0, j, k, m};
            7'h11: res = ~{2'h0, j, k, m};
            7'h12: res = {18'h0, j, k};
            7'h13: res = sje[23:0];
            7'h14: res = b_m[{j, k}];
            7'h15: begin
                wr = 1'b0;
                b_m[{j, k}] = a_m[i];
            end
            7'h16: res = popcnt(sje);
            7'h17: res = lzc(sje);
            7'h18: res = aj + ak;
            7'h19: res = aj - ak;
            7'h1a: res = aj * ak;
            7'h1b: begin
                if (j == 3'h0) res = {19'h0, ti};
                else if (ok && k == 3'h0) res = {3'h5, ch, 11'h2a1, ch};
                else if (ok && k == 3'h1) res = {23'h0, flags_m[ch]};
            end
            default: wr = 1'b0;
        endcase
        if (wr) a_m[i] = res;
        @(posedge sys_clk);
        #1 chk("done", done, 1'b1);
        chk("branch_taken", br_taken, br);
        if (br) chk("branch_target", br_tgt, tgt);
        chk("a_write", a_wr, wr);
        if (wr) chk("a_index", a_idx, i);
        if (wr) chk("a_data", a_data, res);
        chk("err_flags", err_flags, flags_m);
        chk("ready_idle", ready, 1'b1);
    endtask

    initial begin
        logic [31:0] r;
        logic [6:0]  op;
        int          idx;
        seed = 32'h8f20c5d6;
        arst_n = 1'b0;
        issue_valid = 1'b0;
        parcel = 16'h0;
        parcel2 = 16'h0;
        sj_val = 64'h0;
        s0_val = 64'h0;
        mon = 1'b0;
        top_int = 5'h0;
        err_set = 26'h0;
        flags_m = 26'h0;
        for (int n = 0; n < 8; n++) a_m[n] = 24'h0;
        repeat (3) @(posedge sys_clk);
        #1 chk("reset_ready", ready, 1'b1);
        chk("reset_flags", err_flags, 26'h0);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        // Backup store is not reset, so fill every slot before reading
        for (int n = 0; n < 64; n++) begin
            r = $random(seed);
            exec(addr_exec_pkg::OP_IMM_LONG, 3'h1, r[2:0], r[5:3], r[21:6]);
            exec(addr_exec_pkg::OP_TO_B, 3'h1, n[5:3], n[2:0], 16'h0);
        end
        // A0 zero, negative and positive against every branch
        for (int v = 0; v < 3; v++) begin
            exec(7'h12 - v[6:0], 3'h0, 3'h0, 3'h0, 16'h0005);
            for (int b = 8; b < 16; b++) begin
                r = $random(seed);
                exec(b[6:0], r[2:0], r[5:3], r[8:6], r[24:9]);
            end
        end
        // Random mix, one spare opcode beyond the set for the no-op path
        for (int n = 0; n < 600; n++) begin
            r = $random(seed);
            idx = r[31:10] % 22;
            op = (idx == 0) ? 7'h01 : (idx == 21) ? 7'h2a : 7'h07 + idx[6:0];
            exec(op, (op == 7'h01) ? 3'h2 : r[2:0], r[5:3], r[8:6], r[24:9]);
        end
        // Random A values seldom name a valid channel, so walk each one
        for (int c = 2; c < 26; c++) begin
            exec(addr_exec_pkg::OP_IMM_SHORT, 3'h3, c[5:3], c[2:0], 16'h0);
            exec(addr_exec_pkg::OP_CHAN, 3'h4, 3'h3, 3'h0, 16'h0);
            exec(addr_exec_pkg::OP_CHAN, 3'h2, 3'h3, 3'h1, 16'h0);
            exec(addr_exec_pkg::OP_CHAN_CTL, 3'h2, 3'h3, 3'h0, 16'h0);
            exec(addr_exec_pkg::OP_CHAN, 3'h2, 3'h3, 3'h1, 16'h0);
        end
        end_sim;
    end

    // Whole run is near 2630 cycles; allow ample margin
    initial begin
        #2000000;
        num_errors++;
        end_sim;
    end
endmodule // addr_scalar_exec_tb_top
`default_nettype wire
